// *** testbench/can_controller_compat_mode_tb.sv ***
`timescale 1ns/1ps
module can_controller_compat_mode_tb;
  logic        clk, reset, hsel, hwrite, hready, hreadyout, failNext;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic        txRequest, txSingleShot, txRemote, txStarted, txDone, txFailed;
  logic [10:0] txIdent, rxIdent;
  logic [3:0]  txLength, txDataBytes, rxLength;
  logic [63:0] txPayload, rxPayload;
  logic        rxValid, rxReady, rxExtended, rxRemote;
  logic        busReceiving, errorStatus, busOff, errorChange;
  logic [7:0]  startDelay, v;
  logic [10:0] ids [8];
  logic [3:0]  lens [8];
  logic [63:0] pls [8];
  int          mismatches, num_checks, n;
  int          starts = 0;
  int          base;

  can_compat_ctrl dut_u (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .txRequest, .txSingleShot, .txIdent, .txRemote,
    .txLength, .txDataBytes, .txPayload, .txStarted, .txDone, .txFailed, .rxValid, .rxReady,
    .rxExtended, .rxIdent, .rxRemote, .rxLength, .rxPayload, .busReceiving, .errorStatus,
    .busOff, .errorChange);
  can_engine_model model_u (.clk, .reset, .txRequest, .txSingleShot, .startDelay, .failNext,
    .txStarted, .txDone, .txFailed, .rxValid, .rxReady, .rxExtended, .rxIdent, .rxRemote,
    .rxLength, .rxPayload);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) if (txStarted) starts <= starts + 1;

  function automatic logic [7:0] expByte(input logic [10:0] id, input logic remote_request_bit,
                                         input logic [3:0] len, input logic [63:0] pl, input int k);
    return k == 0 ? id[10:3] : k == 1 ? {id[2:0], remote_request_bit, len} : pl[8 * (9 - k) +: 8];
  endfunction : expByte

  function automatic logic [3:0] nBytes(input logic remote_request_bit, input logic [3:0] len);
    return remote_request_bit ? 4'h0 : (len > 4'h8 ? 4'h8 : len);
  endfunction : nBytes

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Byte write, data on the lane of its address
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, 1'b1, 27'h0, a};
    @(posedge clk);
    {hsel, htrans} <= 3'h0;
    hwdata <= {24'h0, d} << (8 * (3 - a[1:0]));
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, 1'b0, 27'h0, a};
    @(posedge clk);
    {hsel, htrans} <= 3'h0;
    @(posedge clk);
    d = hrdata[31:24];
    chk("lanes", hrdata, {4{d}});
    chk("bus answer", {hreadyout, hresp}, 3'b100);
  endtask : rd

  task automatic ck(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a, v);
    chk($sformatf("offset %0d", a), v & m, e);
  endtask : ck

  task automatic waitRbs();
    n = 0;
    do
    begin
      rd(5'h02, v);
      n++;
    end
    while (!v[0] && n < 300);
    chk("rx wait", v[0], 1'b1);
  endtask : waitRbs

  task automatic rxCheck(input int k);
    waitRbs();
    for (int i = 0; i < 2 + lens[k]; i++)
      ck(5'(20 + i), 8'hFF, expByte(ids[k], 1'b0, lens[k], pls[k], i));
    wr(5'h01, 8'h04);
  endtask : rxCheck

  task automatic txRun(input logic remote_request_bit, input logic [3:0] len);
    logic [10:0] id;
    logic [63:0] pl;
    id = 11'($urandom);
    pl = {$urandom, $urandom};
    for (int i = 0; i < 10; i++)
      wr(5'(10 + i), expByte(id, remote_request_bit, len, pl, i));
    wr(5'h01, 8'h01);
    repeat (2) @(posedge clk);
    chk("tx frame", {txRequest, txIdent, txRemote, txLength, txDataBytes},
        {1'b1, id, remote_request_bit, len, nBytes(remote_request_bit, len)});
    chk("tx payload hi", txPayload[63:32], pl[63:32]);
    chk("tx payload lo", txPayload[31:0], pl[31:0]);
    ck(5'h02, 8'h0C, 8'h00);
    wr(5'd10, ~id[10:3]);
    repeat (2) @(posedge clk);
    chk("tx lock", txIdent, id);
  endtask : txRun

  task automatic waitIdle();
    n = 0;
    while (txRequest === 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    chk("tx idle", txRequest, 1'b0);
  endtask : waitIdle

  initial
  begin
    void'($urandom(32'h852ea1dc));
    {hsel, hwrite, haddr, hwdata, htrans, hsize, failNext} = '0;
    {busReceiving, errorStatus, busOff, errorChange} = 4'h0;
    {reset, hready, startDelay} = {1'b1, 1'b1, 8'd20};
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    ck(5'h00, 8'hFF, 8'h01);
    ck(5'h02, 8'hFF, 8'h0C);
    ck(5'h03, 8'hFF, 8'hE0);
    wr(5'h02, 8'hF3);
    {busReceiving, errorStatus, busOff} <= 3'h7;
    ck(5'h02, 8'hFF, 8'hDC);
    {busReceiving, errorStatus, busOff} <= 3'h0;
    wr(5'h04, 8'hA5);
    wr(5'h05, 8'h0F);
    wr(5'h00, 8'h1A);
    ck(5'h00, 8'hFF, 8'h1A);
    wr(5'h1F, 8'h80);
    ck(5'h00, 8'hFF, 8'h00);
    wr(5'h1F, 8'h00);
    ck(5'h00, 8'hFF, 8'h1A);
    errorChange <= 1'b1;
    @(posedge clk);
    errorChange <= 1'b0;
    ck(5'h03, 8'hFF, 8'hE4);
    ck(5'h03, 8'hFF, 8'hE0);
    for (int k = 0; k < 8; k++)
    begin
      ids[k] = {4'hA, 7'($urandom)};
      lens[k] = 4'($urandom_range(8));
      pls[k] = {$urandom, $urandom};
    end
    model_u.sendFrame(1'b1, ids[0], 1'b0, lens[0], pls[0]);
    model_u.sendFrame(1'b0, ids[0] ^ 11'h400, 1'b0, lens[0], pls[0]);
    model_u.sendFrame(1'b0, ids[0], 1'b0, lens[0], pls[0]);
    model_u.sendFrame(1'b0, ids[1], 1'b0, lens[1], pls[1]);
    waitRbs();
    ck(5'h03, 8'hFF, 8'hE1);
    ck(5'h03, 8'hFF, 8'hE1);
    rxCheck(0);
    waitRbs();
    ck(5'h03, 8'hFF, 8'hE1);
    rxCheck(1);
    ck(5'h02, 8'h01, 8'h00);
    ck(5'h03, 8'hFF, 8'hE0);
    for (int k = 0; k < 7; k++)
    begin
      lens[k] = 4'h8;
      model_u.sendFrame(1'b0, ids[k], 1'b0, lens[k], pls[k]);
    end
    waitRbs();
    repeat (100) @(posedge clk);
    ck(5'h02, 8'h02, 8'h00);
    for (int k = 0; k < 6; k++)
      rxCheck(k);
    ck(5'h02, 8'h03, 8'h02);
    ck(5'h03, 8'hFF, 8'hE8);
    wr(5'h01, 8'h08);
    ck(5'h02, 8'h02, 8'h00);
    txRun(1'b0, 4'hC);
    waitIdle();
    ck(5'h02, 8'h0C, 8'h0C);
    ck(5'h03, 8'hFF, 8'hE0);
    wr(5'h00, 8'h1E);
    txRun(1'b1, 4'h5);
    waitIdle();
    ck(5'h03, 8'hFF, 8'hE2);
    ck(5'h03, 8'hFF, 8'hE0);
    failNext <= 1'b1;
    base = starts;
    txRun(1'b0, 4'h2);
    for (n = 0; n < 200 && starts == base; n++)
      @(posedge clk);
    wr(5'h01, 8'h02);
    waitIdle();
    chk("attempts", starts - base, 32'h1);
    chk("single after abort", txSingleShot, 1'b1);
    ck(5'h02, 8'h08, 8'h00);
    failNext <= 1'b0;
    startDelay <= 8'd80;
    base = starts;
    txRun(1'b0, 4'h1);
    wr(5'h01, 8'h02);
    repeat (2) @(posedge clk);
    chk("abort", {txRequest, 31'(starts - base)}, 32'h0);
    failNext <= 1'b1;
    startDelay <= 8'd20;
    base = starts;
    wr(5'h01, 8'h03);
    repeat (2) @(posedge clk);
    chk("single shot req", txRequest, 1'b1);
    waitIdle();
    chk("single shot", {txSingleShot, 31'(starts - base)}, {1'b1, 31'h1});
    ck(5'h02, 8'h08, 8'h00);
    wr(5'h00, 8'h1F);
    ck(5'h00, 8'h01, 8'h01);
    report_and_stop();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : can_controller_compat_mode_tb

// *** testbench/can_engine_model.sv ***
`timescale 1ns/1ps
module can_engine_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Transmit side
  input  wire logic        txRequest,
  input  wire logic        txSingleShot,
  input  wire logic [7:0]  startDelay,
  input  wire logic        failNext,
  output logic             txStarted,
  output logic             txDone,
  output logic             txFailed,
  // Receive side
  output logic             rxValid,
  input  wire logic        rxReady,
  output logic             rxExtended,
  output logic      [10:0] rxIdent,
  output logic             rxRemote,
  output logic      [3:0]  rxLength,
  output logic      [63:0] rxPayload
);
  initial
  begin
    {txStarted, txDone, txFailed, rxValid} = 4'h0;
    {rxExtended, rxIdent, rxRemote, rxLength, rxPayload} = '0;
  end

  // Start after a delay, then finish or fail; retries while still pending
  always
  begin
    @(posedge clk);
    if (txRequest && !reset)
    begin
      repeat (startDelay) @(posedge clk);
      if (txRequest)
      begin
        txStarted <= 1'b1;
        @(posedge clk);
        txStarted <= 1'b0;
        repeat (8) @(posedge clk);
        txFailed <= failNext;
        txDone   <= !failNext;
        @(posedge clk);
        {txFailed, txDone} <= 2'h0;
        if (txSingleShot)
          wait (!txRequest);
      end
    end
  end

  // One frame, held until taken; fields scrambled afterwards
  task automatic sendFrame(input logic ext, input logic [10:0] id, input logic remote_request_bit,
                           input logic [3:0] len, input logic [63:0] pl);
    @(posedge clk);
    rxValid <= 1'b1;
    {rxExtended, rxIdent, rxRemote, rxLength, rxPayload} <= {ext, id, remote_request_bit, len, pl};
    do
      @(posedge clk);
    while (!rxReady);
    rxValid <= 1'b0;
    {rxExtended, rxIdent, rxRemote, rxLength, rxPayload} <= ~{ext, id, remote_request_bit, len, pl};
  endtask : sendFrame
endmodule : can_engine_model

// *** verilog/can_compat_ctrl.sv ***
`timescale 1ns/1ps
`include "can_compat_defs.svh"
module can_compat_ctrl #(
  parameter int FIFO_BYTES = 64,
  parameter int AW         = $clog2(FIFO_BYTES)
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  // Transmit frame to bit engine
  output logic             txRequest,
  output logic             txSingleShot,
  output logic      [10:0] txIdent,
  output logic             txRemote,
  output logic      [3:0]  txLength,
  output logic      [3:0]  txDataBytes,
  output logic      [63:0] txPayload,
  input  wire logic        txStarted,
  input  wire logic        txDone,
  input  wire logic        txFailed,
  // Received frame from bit engine
  input  wire logic        rxValid,
  output logic             rxReady,
  input  wire logic        rxExtended,
  input  wire logic [10:0] rxIdent,
  input  wire logic        rxRemote,
  input  wire logic [3:0]  rxLength,
  input  wire logic [63:0] rxPayload,
  // Bus state from bit engine
  input  wire logic        busReceiving,
  input  wire logic        errorStatus,
  input  wire logic        busOff,
  input  wire logic        errorChange
);

  function automatic logic [3:0] dataBytes(input logic remote_request_bit, input logic [3:0] payload_length_code);
    dataBytes = remote_request_bit ? 4'h0 : ((payload_length_code > 4'h8) ? 4'h8 : payload_length_code);
  endfunction : dataBytes

  function automatic logic [7:0] frameByte(input can_compat_pkg::rxFrame_t f,
                                           input logic [3:0] idx);
    logic [79:0] flat;
    flat      = f[79:0];
    frameByte = flat[79 - 8 * int'(idx) -: 8];
  endfunction : frameByte

  // Register port
  logic        wrPend_q;
  logic [4:0]  wrAddr_q;
  logic [31:0] rdData_q;
  logic [7:0]  control_q;
  logic [7:0]  clkDiv_q;
  logic [7:0]  accCode_q;
  logic [7:0]  accMask_q;
  logic [7:0]  txBuf_q [0:9];
  logic [7:0]  rdByte;
  logic [7:0]  wByte;

  wire       accept  = hsel & hready & htrans[1];
  wire       rdNow   = accept & ~hwrite;
  wire [4:0] rAddr   = haddr[4:0];
  wire       enh     = clkDiv_q[`CAN_CLKDIV_MODE];
  wire       inReset = control_q[`CAN_CR_RESET];
  wire       wrEn    = wrPend_q & ~enh;
  wire       wrCtl   = wrEn & (wrAddr_q == `CAN_OFS_CONTROL);
  wire       wrCmd   = wrEn & (wrAddr_q == `CAN_OFS_COMMAND) & ~inReset;
  wire       wrCode  = wrEn & (wrAddr_q == `CAN_OFS_ACC_CODE) & inReset;
  wire       wrMask  = wrEn & (wrAddr_q == `CAN_OFS_ACC_MASK) & inReset;
  wire       wrDiv   = wrPend_q & (wrAddr_q == `CAN_OFS_CLKDIV);
  wire       txbHit  = (wrAddr_q >= `CAN_OFS_TXB_FIRST) & (wrAddr_q <= `CAN_OFS_TXB_LAST);
  wire       irRead  = rdNow & ~enh & (rAddr == `CAN_OFS_INTR);
  wire       cmdTx   = wrCmd & wByte[`CAN_CMD_TX];
  wire       cmdAbt  = wrCmd & wByte[`CAN_CMD_ABORT];
  wire       cmdRel  = wrCmd & wByte[`CAN_CMD_RELEASE];
  wire       cmdClr  = wrCmd & wByte[`CAN_CMD_CLR_OVR];

  // Lowest address travels on the top byte lane
  assign wByte = hwdata[8 * (3 - int'(wrAddr_q[1:0])) +: 8];
  assign hrdata    = rdData_q;
  assign hreadyout = 1'b1;
  assign hresp     = 2'b00;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 5'h00;
      rdData_q <= 32'h0000_0000;
    end
    else
    begin
      wrPend_q <= accept & hwrite;
      wrAddr_q <= haddr[4:0];
      if (rdNow)
        rdData_q <= {4{rdByte}};
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      control_q <= `CAN_CONTROL_RST;
      clkDiv_q  <= `CAN_CLKDIV_RST;
      accCode_q <= 8'h00;
      accMask_q <= 8'hFF;
    end
    else
    begin
      if (wrCtl)
        control_q <= {3'b000, wByte[4:0]};
      if (wrDiv)
        clkDiv_q <= wByte;
      if (wrCode)
        accCode_q <= wByte;
      if (wrMask)
        accMask_q <= wByte;
    end
  end

  // Transmit control
  logic txPending_q;
  logic txActive_q;
  logic txSingle_q;
  logic txComplete_q;
  logic [3:0] txIdx;

  wire tbs   = ~txPending_q;
  wire wrTxb = wrEn & txbHit & tbs;
  assign txIdx = 4'(wrAddr_q - `CAN_OFS_TXB_FIRST);

  always_ff @(posedge clk)
  begin
    if (wrTxb)
      txBuf_q[txIdx] <= wByte;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      txPending_q  <= 1'b0;
      txActive_q   <= 1'b0;
      txSingle_q   <= 1'b0;
      txComplete_q <= 1'b1;
    end
    else if (inReset)
    begin
      txPending_q <= 1'b0;
      txActive_q  <= 1'b0;
    end
    else if (cmdTx & ~txPending_q)
    begin
      txPending_q  <= 1'b1;
      txSingle_q   <= cmdAbt;
      txComplete_q <= 1'b0;
    end
    else if (cmdAbt & txPending_q & ~txActive_q & ~txStarted)
      txPending_q <= 1'b0;
    else
    begin
      if (txStarted)
        txActive_q <= 1'b1;
      if (cmdAbt & (txActive_q | txStarted))
        txSingle_q <= 1'b1;
      if (txDone)
      begin
        txPending_q  <= 1'b0;
        txActive_q   <= 1'b0;
        txComplete_q <= 1'b1;
      end
      else if (txFailed)
      begin
        txActive_q <= 1'b0;
        if (txSingle_q | cmdAbt)
          txPending_q <= 1'b0;
      end
    end
  end

  assign txRequest    = txPending_q;
  assign txSingleShot = txSingle_q;
  assign txIdent      = {txBuf_q[0], txBuf_q[1][7:5]};
  assign txRemote     = txBuf_q[1][4];
  assign txLength     = txBuf_q[1][3:0];
  assign txDataBytes  = dataBytes(txBuf_q[1][4], txBuf_q[1][3:0]);
  assign txPayload    = {txBuf_q[2], txBuf_q[3], txBuf_q[4], txBuf_q[5],
                         txBuf_q[6], txBuf_q[7], txBuf_q[8], txBuf_q[9]};

  // Two-entry frame buffer between bit engine and FIFO writer
  can_compat_pkg::rxFrame_t slot_q [0:1];
  logic [1:0] slotCnt_q;
  logic       slotRd_q;
  logic       slotWr_q;
  logic       pop;

  wire                      push = rxValid & rxReady;
  wire can_compat_pkg::rxFrame_t head = slot_q[slotRd_q];
  assign rxReady = (slotCnt_q != 2'd2);

  always_ff @(posedge clk)
  begin
    if (push)
      slot_q[slotWr_q] <= {rxExtended, rxIdent, rxRemote, rxLength, rxPayload};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      slotCnt_q <= 2'd0;
      slotRd_q  <= 1'b0;
      slotWr_q  <= 1'b0;
    end
    else
    begin
      slotCnt_q <= slotCnt_q + 2'(push) - 2'(pop);
      slotRd_q  <= slotRd_q ^ pop;
      slotWr_q  <= slotWr_q ^ push;
    end
  end

  // Receive FIFO and its writer
  logic [7:0]   mem [0:FIFO_BYTES-1];
  logic [AW-1:0] wPtr_q;
  logic [AW-1:0] rPtr_q;
  logic [AW:0]   byteCnt_q;
  logic [AW:0]   msgCnt_q;
  logic [3:0]    idx_q;
  logic [3:0]    len_q;
  can_compat_pkg::rxFrame_t cur_q;
  can_compat_pkg::wrState_t state_q;
  logic          ovrPend_q;
  logic          ovrShown_q;

  wire [3:0]  headLen  = 4'h2 + dataBytes(head[68], head[67:64]);
  wire [7:0]  hdrByte  = mem[rPtr_q + AW'(1)];
  wire [3:0]  relLen   = 4'h2 + dataBytes(hdrByte[4], hdrByte[3:0]);
  wire [AW:0] space    = (AW + 1)'(FIFO_BYTES) - byteCnt_q;
  wire        match    = ((head[79:72] ^ accCode_q) & ~accMask_q) == 8'h00;
  wire        wanted   = ~head[80] & ~inReset & match;
  wire        fits     = space >= (AW + 1)'(headLen);
  wire        idle     = (state_q == can_compat_pkg::WR_IDLE);
  wire        writing  = (state_q == can_compat_pkg::WR_BYTES);
  wire        commit   = writing & (idx_q == len_q - 4'h1);
  wire        dropOvr  = idle & (slotCnt_q != 2'd0) & wanted & ~fits;
  wire        relNow   = cmdRel & (msgCnt_q != '0);
  wire        rbs      = (msgCnt_q != '0);
  wire        ovrStat  = ovrPend_q & (msgCnt_q == '0);
  assign pop = idle & (slotCnt_q != 2'd0);

  always_ff @(posedge clk)
  begin
    if (writing)
      mem[wPtr_q] <= frameByte(cur_q, idx_q);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q   <= can_compat_pkg::WR_IDLE;
      cur_q     <= '0;
      idx_q     <= 4'h0;
      len_q     <= 4'h0;
      wPtr_q    <= '0;
      rPtr_q    <= '0;
      byteCnt_q <= '0;
      msgCnt_q  <= '0;
    end
    else
    begin
      unique case (state_q)
        can_compat_pkg::WR_IDLE:
          if (pop & wanted & fits)
          begin
            state_q <= can_compat_pkg::WR_BYTES;
            cur_q   <= head;
            len_q   <= headLen;
            idx_q   <= 4'h0;
          end
        can_compat_pkg::WR_BYTES:
        begin
          idx_q <= idx_q + 4'h1;
          if (commit)
            state_q <= can_compat_pkg::WR_IDLE;
        end
      endcase
      if (writing)
        wPtr_q <= wPtr_q + AW'(1);
      if (relNow)
        rPtr_q <= rPtr_q + AW'(relLen);
      byteCnt_q <= byteCnt_q + (AW + 1)'(writing) - (relNow ? (AW + 1)'(relLen) : '0);
      msgCnt_q  <= msgCnt_q + (AW + 1)'(commit) - (AW + 1)'(relNow);
    end
  end

  // Status and interrupt flags; a hardware set wins over a clear
  logic rxIrq_q;
  logic txIrq_q;
  logic errIrq_q;
  logic ovrIrq_q;

  wire rxMore = relNow & (msgCnt_q > (AW + 1)'(1));
  wire setRx  = control_q[`CAN_CR_RX_IE] & (commit | rxMore);
  wire setTx  = control_q[`CAN_CR_TX_IE] & txDone & txPending_q & ~inReset;
  wire setErr = control_q[`CAN_CR_ERR_IE] & errorChange;
  wire setOvr = control_q[`CAN_CR_OVR_IE] & ovrStat & ~ovrShown_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ovrPend_q  <= 1'b0;
      ovrShown_q <= 1'b0;
      rxIrq_q    <= 1'b0;
      txIrq_q    <= 1'b0;
      errIrq_q   <= 1'b0;
      ovrIrq_q   <= 1'b0;
    end
    else
    begin
      ovrPend_q  <= dropOvr | (ovrPend_q & ~cmdClr);
      ovrShown_q <= ovrStat;
      rxIrq_q    <= setRx | (rxIrq_q & ~relNow);
      txIrq_q    <= setTx | (txIrq_q & ~irRead);
      errIrq_q   <= setErr | (errIrq_q & ~irRead);
      ovrIrq_q   <= setOvr | (ovrIrq_q & ~irRead);
    end
  end

  // Read selection; status is computed live and has no write path
  wire [7:0] statusByte = {busOff, errorStatus, txActive_q, busReceiving,
                           txComplete_q, tbs, ovrStat, rbs};
  wire [7:0] intrByte   = {`CAN_IR_FIXED, ovrIrq_q, errIrq_q, txIrq_q, rxIrq_q};
  wire       rxbHit     = (rAddr >= `CAN_OFS_RXB_FIRST) & (rAddr <= `CAN_OFS_RXB_LAST);
  wire       txbRdHit   = (rAddr >= `CAN_OFS_TXB_FIRST) & (rAddr <= `CAN_OFS_TXB_LAST);
  wire [7:0] rxbByte    = mem[rPtr_q + AW'(rAddr - `CAN_OFS_RXB_FIRST)];
  wire [7:0] txbByte    = txBuf_q[4'(rAddr - `CAN_OFS_TXB_FIRST)];

  always_comb
  begin
    rdByte = 8'h00;
    if (rAddr == `CAN_OFS_CLKDIV)
      rdByte = clkDiv_q;
    else if (~enh)
    begin
      if (rAddr == `CAN_OFS_CONTROL)
        rdByte = control_q;
      else if (rAddr == `CAN_OFS_COMMAND)
        rdByte = 8'hFF;
      else if (rAddr == `CAN_OFS_STATUS)
        rdByte = statusByte;
      else if (rAddr == `CAN_OFS_INTR)
        rdByte = intrByte;
      else if (rAddr == `CAN_OFS_ACC_CODE)
        rdByte = accCode_q;
      else if (rAddr == `CAN_OFS_ACC_MASK)
        rdByte = accMask_q;
      else if (txbRdHit)
        rdByte = txbByte;
      else if (rxbHit)
        rdByte = rxbByte;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_IR_FIXED: assert property (irRead |=>
    hrdata[7:4] == 4'hE && hrdata[31:28] == 4'hE)
    else $error("interrupt register fixed bits wrong");
  AST_LANES: assert property (rdNow |=>
    hrdata[31:24] == hrdata[7:0] && hrdata[23:16] == hrdata[15:8])
    else $error("read byte not copied to all lanes");
  AST_RESET_MODE: assert property (wrCtl && wByte[0] |=> ##1 !txRequest)
    else $error("transmit request survives reset mode");
  AST_TX_START: assert property (cmdTx && !txPending_q && !inReset |=>
    txRequest && !txComplete_q)
    else $error("transmit request not raised");
  AST_ABORT: assert property (cmdAbt && !cmdTx && txPending_q && !txActive_q
    && !txStarted && !inReset |=> !txRequest)
    else $error("abort did not cancel pending frame");
  AST_NO_RETRY: assert property (txActive_q && txSingle_q && txFailed && !inReset
    |=> !txRequest)
    else $error("started aborted frame retried");
  AST_TXB_LOCK: assert property (txRequest && wrEn && txbHit |=>
    $stable(txPayload) && $stable(txIdent))
    else $error("transmit buffer written while locked");
  AST_CLR_OVR: assert property (cmdClr && !dropOvr |=> !ovrPend_q)
    else $error("overrun not cleared");
  AST_RBS_LAST: assert property (relNow && msgCnt_q == (AW + 1)'(1) && !commit
    |=> !rbs)
    else $error("receive buffer status not cleared");
  AST_OVR_SHOW: assert property (rdNow && !enh && rAddr == `CAN_OFS_STATUS
    && ovrPend_q && msgCnt_q != '0 |=> !hrdata[1])
    else $error("overrun shown before FIFO read out");
  AST_FILTER: assert property (idle && slotCnt_q != 2'd0 && !match |=>
    idle && $stable(wPtr_q))
    else $error("filtered frame entered FIFO");
  AST_IRQ_EN: assert property ($rose(rxIrq_q) |-> $past(control_q[`CAN_CR_RX_IE]))
    else $error("receive flag set while disabled");
  AST_WRITER_PACE: assert property (writing |-> ##[1:10] idle)
    else $error("frame store slower than a bus frame");

endmodule : can_compat_ctrl

// *** verilog/can_compat_defs.svh ***
// How it works
// - Starts in reset mode; clearing reset request enters operating mode, setting returns.
// - Clock divider bit selects enhanced mode; register map then changes.
// - Byte registers; host uses byte access; read byte copied onto every lane.
// - Big endian port: lowest address on the top lane; bit 7 is MSB.
// - Writing transmit request starts sending the transmit buffer frame.
// - Abort cancels a frame not yet started; a started frame is not retried after an abort.
// - Host releases after reading; a waiting frame sets status and interrupt again.
// - Clear overrun command clears the overrun status flag.
// - Status register is read only and shows live state.
// - Receive buffer status clears on release, sets again while frames remain.
// - Overrun marks a dropped accepted frame, shown once the FIFO is read out.
// - Transmit buffer status is one when writable; zero and locked while sending.
// - Transmission complete clears on request, sets after a successful frame.
// - Interrupt flags set only while their control enable bit is set.
// - Reading interrupt register clears flags except receive, cleared by release.
// - Interrupt register bits 7 to 5 read one, bit 4 reads zero.
// - Only base format frames; extended format frames are ignored.
// - Remote frames carry no data bytes but keep the length code.
// - Length codes above eight still send only eight data bytes.
// - Receive buffer at 20 to 29 shows oldest entry of 64-byte FIFO.
// - Filter compares identifier bits 10 to 3 where mask is zero; match stored.
// - Bus bit rates up to 1 Mb/s are supported.
`ifndef CAN_COMPAT_DEFS_SVH
`define CAN_COMPAT_DEFS_SVH

`define CAN_OFS_CONTROL   5'h00
`define CAN_OFS_COMMAND   5'h01
`define CAN_OFS_STATUS    5'h02
`define CAN_OFS_INTR      5'h03
`define CAN_OFS_ACC_CODE  5'h04
`define CAN_OFS_ACC_MASK  5'h05
`define CAN_OFS_TXB_FIRST 5'h0A
`define CAN_OFS_TXB_LAST  5'h13
`define CAN_OFS_RXB_FIRST 5'h14
`define CAN_OFS_RXB_LAST  5'h1D
`define CAN_OFS_CLKDIV    5'h1F

`define CAN_CR_RESET    0
`define CAN_CR_RX_IE    1
`define CAN_CR_TX_IE    2
`define CAN_CR_ERR_IE   3
`define CAN_CR_OVR_IE   4
`define CAN_CMD_TX      0
`define CAN_CMD_ABORT   1
`define CAN_CMD_RELEASE 2
`define CAN_CMD_CLR_OVR 3
`define CAN_CLKDIV_MODE 7

`define CAN_CONTROL_RST 8'h01
`define CAN_CLKDIV_RST  8'h00
`define CAN_IR_FIXED    4'hE

`define CAN_CLK_HZ       200000000
`define CAN_MAX_BIT_RATE 1000000
`define CAN_BIT_CYCLES   (`CAN_CLK_HZ / `CAN_MAX_BIT_RATE)

`endif

// *** verilog/can_compat_pkg.sv ***
package can_compat_pkg;
  typedef enum logic { WR_IDLE, WR_BYTES } wrState_t;
  // {extended, ident[10:0], remote, length[3:0], payload[63:0]}
  typedef logic [80:0] rxFrame_t;
endpackage : can_compat_pkg
